/* File: rtl/acr_pkg.sv */
// constants for the converter configuration register block
package acr_pkg;
    localparam logic [1:0]  ACR_PTR_CONFIG      = 2'h1;
    localparam logic [15:0] ACR_CFG_RESET       = 16'h8583;
    localparam int          ACR_BIT_START       = 15;
    localparam int          ACR_LSB_INPUT       = 12;
    localparam int          ACR_LSB_GAIN        = 9;
    localparam int          ACR_BIT_MODE        = 8;
    localparam int          ACR_LSB_RATE        = 5;
    localparam int          ACR_BIT_CMP_MODE    = 4;
    localparam int          ACR_BIT_POL         = 3;
    localparam int          ACR_BIT_LATCH       = 2;
    localparam int          ACR_LSB_QUEUE       = 0;
    localparam logic [1:0]  ACR_QUEUE_OFF       = 2'h3;
    localparam logic        ACR_MODE_CONT       = 1'b0;
    localparam logic        ACR_MODE_SINGLE     = 1'b1;
    localparam logic [2:0]  ACR_GAIN_6V144      = 3'h0;
    localparam logic [2:0]  ACR_GAIN_2V048      = 3'h2;
    localparam logic [2:0]  ACR_GAIN_0V256      = 3'h5;
    localparam logic [2:0]  ACR_RATE_860        = 3'h7;
    typedef enum logic [1:0] {
        ACR_ST_DOWN   = 2'b00,
        ACR_ST_SINGLE = 2'b01,
        ACR_ST_CONT   = 2'b10
    } acr_state_t;
endpackage : acr_pkg

/* File: rtl/acr_field_reg.sv */
`timescale 1ns/10ps
// one writable field of the configuration register
module acr_field_reg #(
    parameter int          W   = 1,
    parameter logic [15:0] RST = 16'h0000
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // write side
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // stored value
    output logic      [W-1:0] q
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST[W-1:0];
        end else if (wr_en) begin
            q <= wr_data;
        end
    end
endmodule // acr_field_reg

/* File: rtl/acr_config_reg.sv */
`timescale 1ns/10ps
// converter configuration register with conversion start and status
// Function
// RL1 - pointer 01b selects this register; it powers up as 8583h
// RL2 - sixteen bits hold mode, input, rate, range and comparator controls
// RL3 - writing start bit 1 in power-down starts one conversion; 0 does nothing, except a write with mode bit 0 starts continuous
// RL4 - start writes act only in power-down; ignored during a conversion
// RL5 - start/status bit reads 0 while converting, 1 otherwise
// RL6 - single-shot returns to power-down after its conversion ends
// RL7 - gain field: 000 6.144 V, 010 2.048 V default, 101-111 0.256 V
// RL8 - mode bit 0 continuous, 1 single-shot with power-down, reset 1
// RL9 - rate field codes 000-111 give 8 to 860 SPS, reset 100
// RL10 - queue field needs 1, 2 or 4 exceedances; 11 disables the alert
module acr_config_reg (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // register access from the two-wire target engine
    input  wire logic [1:0]  reg_ptr,
    input  wire logic        wr_stb,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] rd_data,
    // converter core handshake
    input  wire logic        conv_done,
    output logic             conv_start,
    output logic             conv_busy,
    // decoded controls
    output logic      [2:0]  input_select,
    output logic      [2:0]  gain_range_select,
    output logic             single_shot_mode,
    output logic      [2:0]  sample_rate_select,
    output logic             alert_window_mode,
    output logic             alert_polarity,
    output logic             alert_latch,
    output logic      [1:0]  alert_queue_count,
    output logic             alert_enable
);
    import acr_pkg::*;

    acr_state_t state_r;
    acr_state_t state_nxt;
    logic       start_r;
    logic [2:0] in_q;
    logic [2:0] gain_q;
    logic       mode_q;
    logic [2:0] rate_q;
    logic       cmp_win_q;
    logic       cmp_pol_q;
    logic       cmp_lat_q;
    logic [1:0] que_q;
    logic       alert_en_r;

    wire sel_cfg    = (reg_ptr == ACR_PTR_CONFIG); // RL1
    wire cfg_wr     = wr_stb && sel_cfg;
    wire powered_dn = (state_r == ACR_ST_DOWN);
    wire start_req  = cfg_wr && wr_data[ACR_BIT_START] && powered_dn; // RL3 RL4
    wire new_mode   = cfg_wr ? wr_data[ACR_BIT_MODE] : mode_q;
    wire busy_w     = (state_r != ACR_ST_DOWN);
    wire status_bit = ~busy_w; // RL5

    // field storage, one instance per field
    acr_field_reg #(.W(3), .RST(ACR_CFG_RESET >> ACR_LSB_INPUT)) u_in (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_LSB_INPUT +: 3]),
        .q       (in_q)
    ); // RL2
    acr_field_reg #(.W(3), .RST(ACR_CFG_RESET >> ACR_LSB_GAIN)) u_gain (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_LSB_GAIN +: 3]),
        .q       (gain_q)
    ); // RL7
    acr_field_reg #(.W(1), .RST(ACR_CFG_RESET >> ACR_BIT_MODE)) u_mode (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_BIT_MODE]),
        .q       (mode_q)
    ); // RL8
    acr_field_reg #(.W(3), .RST(ACR_CFG_RESET >> ACR_LSB_RATE)) u_rate (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_LSB_RATE +: 3]),
        .q       (rate_q)
    ); // RL9
    // comparator controls, one flop per single-bit field, two for the queue
    acr_field_reg #(.W(1), .RST(ACR_CFG_RESET >> ACR_BIT_CMP_MODE)) u_cmp_win (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_BIT_CMP_MODE]),
        .q       (cmp_win_q)
    ); // RL2
    acr_field_reg #(.W(1), .RST(ACR_CFG_RESET >> ACR_BIT_POL)) u_cmp_pol (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_BIT_POL]),
        .q       (cmp_pol_q)
    ); // RL2
    acr_field_reg #(.W(1), .RST(ACR_CFG_RESET >> ACR_BIT_LATCH)) u_cmp_lat (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_BIT_LATCH]),
        .q       (cmp_lat_q)
    ); // RL2
    acr_field_reg #(.W(2), .RST(ACR_CFG_RESET >> ACR_LSB_QUEUE)) u_que (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (cfg_wr),
        .wr_data (wr_data[ACR_LSB_QUEUE +: 2]),
        .q       (que_q)
    ); // RL10

    // conversion sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ACR_ST_DOWN: begin
                if (cfg_wr && new_mode == ACR_MODE_CONT) begin
                    state_nxt = ACR_ST_CONT;
                end else if (start_req) begin
                    state_nxt = ACR_ST_SINGLE; // RL3
                end
            end
            ACR_ST_SINGLE: begin
                if (conv_done) begin
                    state_nxt = (mode_q == ACR_MODE_CONT) ? ACR_ST_CONT : ACR_ST_DOWN; // RL6
                end
            end
            ACR_ST_CONT: begin
                if (new_mode == ACR_MODE_SINGLE) begin
                    state_nxt = ACR_ST_DOWN; // RL8
                end
            end
            default: begin
                state_nxt = ACR_ST_DOWN;
            end
        endcase
    end

    // a start pulse leaves power-down, or repeats after each continuous result
    wire leave_down = powered_dn && (state_nxt != ACR_ST_DOWN);
    wire stay_cont  = (state_r == ACR_ST_CONT) && (state_nxt == ACR_ST_CONT);
    wire cont_again = stay_cont && conv_done;
    wire start_nxt  = leave_down || cont_again; // RL3

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ACR_ST_DOWN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_r <= 1'b0;
        end else begin
            start_r <= start_nxt;
        end
    end

    // readback and control outputs, all registered
    wire [2:0]  cmp_word = {cmp_win_q, cmp_pol_q, cmp_lat_q};
    wire [15:0] cfg_word = {status_bit, in_q, gain_q, mode_q, rate_q,
                            cmp_word, que_q}; // RL2 RL5
    wire [15:0] rd_nxt   = sel_cfg ? cfg_word : 16'h0000; // RL1
    wire        busy_nxt = (state_nxt != ACR_ST_DOWN);

    // alert enable follows the queue field in the same edge as its write
    wire [1:0]  que_nxt      = cfg_wr ? wr_data[ACR_LSB_QUEUE +: 2] : que_q;
    wire        alert_en_nxt = (que_nxt != ACR_QUEUE_OFF); // RL10
    wire [1:0]  que_rst      = ACR_CFG_RESET[ACR_LSB_QUEUE +: 2];
    wire        alert_en_rst = (que_rst != ACR_QUEUE_OFF);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_en_r <= (ACR_CFG_RESET[ACR_LSB_QUEUE +: 2] != ACR_QUEUE_OFF);
        end else begin
            alert_en_r <= alert_en_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data   <= ACR_CFG_RESET; // RL1
            conv_busy <= 1'b0;
        end else begin
            rd_data   <= rd_nxt;
            conv_busy <= busy_nxt;
        end
    end

    assign conv_start         = start_r;
    assign input_select       = in_q;
    assign gain_range_select  = gain_q;
    assign single_shot_mode   = mode_q;
    assign sample_rate_select = rate_q;
    assign alert_window_mode  = cmp_win_q;
    assign alert_polarity     = cmp_pol_q;
    assign alert_latch        = cmp_lat_q;
    assign alert_queue_count  = que_q;
    // registered so the pin enable never glitches on a write
    assign alert_enable       = alert_en_r; // RL10
endmodule // acr_config_reg

/* File: tb/acr_asserts.sv */
// port checker for the configuration register
`timescale 1ns/10ps
module acr_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [1:0]  reg_ptr,
    input wire logic        wr_stb,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] rd_data,
    input wire logic        conv_done,
    input wire logic        conv_start,
    input wire logic        conv_busy,
    input wire logic [2:0]  gain_range_select,
    input wire logic        single_shot_mode,
    input wire logic [2:0]  sample_rate_select,
    input wire logic [1:0]  alert_queue_count,
    input wire logic        alert_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire tk = wr_stb && reg_ptr == 2'h1;
    property p_start; tk && !conv_busy && (wr_data[15] || !wr_data[8]) |=> conv_start && conv_busy; endproperty
    a_start: assert property (p_start) else $error("start write not taken");
    property p_zero; tk && !conv_busy && !wr_data[15] && wr_data[8] |=> !conv_start; endproperty
    a_zero: assert property (p_zero) else $error("zero start bit began a conversion");
    property p_ign; tk && conv_busy && single_shot_mode && wr_data[8] |=> !conv_start; endproperty
    a_ign: assert property (p_ign) else $error("start accepted while busy");
    property p_stat; reg_ptr == 2'h1 |=> rd_data[15] == !$past(conv_busy); endproperty
    a_stat: assert property (p_stat) else $error("status bit wrong");
    property p_done; single_shot_mode && conv_busy && conv_done |=> !conv_busy; endproperty
    a_done: assert property (p_done) else $error("no return to power-down");
    property p_once; conv_start |=> !conv_start; endproperty
    a_once: assert property (p_once) else $error("start pulse too long");
    property p_fld; tk |=> {gain_range_select, single_shot_mode, sample_rate_select} == $past(wr_data[11:5]); endproperty
    a_fld: assert property (p_fld) else $error("field write lost");
    property p_que; tk |=> alert_queue_count == $past(wr_data[1:0]) && alert_enable == ($past(wr_data[1:0]) != 2'h3); endproperty
    a_que: assert property (p_que) else $error("queue field wrong");
    property p_hold; !tk |=> $stable(gain_range_select) && $stable(sample_rate_select); endproperty
    a_hold: assert property (p_hold) else $error("field changed without write");
    property p_oth; reg_ptr != 2'h1 |=> rd_data == 16'h0000; endproperty
    a_oth: assert property (p_oth) else $error("other pointer read not zero");
endmodule // acr_asserts
bind acr_config_reg acr_asserts acr_asserts_i (.*);

/* File: tb/acr_core_model.sv */
// converter core model: one done pulse per start after a set latency
`timescale 1ns/10ps
module acr_core_model (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       conv_start,
    input wire logic [3:0] lat,
    output logic           conv_done
);
    logic [3:0] cnt_r;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt_r == 4'h1);
            if (conv_start) cnt_r <= lat;
            else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
        end
    end
endmodule // acr_core_model

/* File: tb/tb_top.sv */
// bench for the configuration register block
`timescale 1ns/10ps
module tb_top;
    import acr_pkg::*;
    logic        sys_clk, rst_n, wr_stb, conv_done, conv_start, conv_busy, aen;
    logic [1:0]  reg_ptr;
    logic [15:0] wr_data, rd_data, d;
    wire  [14:0] f;
    logic [14:0] cfg;
    logic [3:0]  lat;
    int          bad_count, n_compared, seed = 23, busy, cont, starts, n_starts;
    acr_config_reg acr_config_reg_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_ptr(reg_ptr),
        .wr_stb(wr_stb), .wr_data(wr_data), .rd_data(rd_data), .conv_done(conv_done),
        .conv_start(conv_start), .conv_busy(conv_busy), .input_select(f[14:12]),
        .gain_range_select(f[11:9]), .single_shot_mode(f[8]), .sample_rate_select(f[7:5]),
        .alert_window_mode(f[4]), .alert_polarity(f[3]), .alert_latch(f[2]),
        .alert_queue_count(f[1:0]), .alert_enable(aen));
    acr_core_model acr_core_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .conv_start(conv_start), .lat(lat), .conv_done(conv_done));
    task chk(string nm, logic [15:0] s, logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task summarize;
        if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task rdchk;
        repeat (2) @(posedge sys_clk);
        #1 chk("readback", rd_data, {busy == 0, cfg});
        chk("fields", {1'b0, f}, {1'b0, cfg});
        chk("alert_en", aen, cfg[1:0] != 2'h3);
    endtask
    task wr(logic [1:0] p, logic [15:0] v);
        @(posedge sys_clk);
        reg_ptr <= p;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        reg_ptr <= ACR_PTR_CONFIG;
        if (p == ACR_PTR_CONFIG) begin
            cfg = v[14:0];
            if (busy == 0 && (v[15] || !v[8])) begin
                busy = 1;
                cont = !v[8];
                starts++;
            end else if (cont && v[8]) {busy, cont} = 0;
        end
        rdchk();
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (conv_start === 1'b1) n_starts++;
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        summarize();
    end
    initial begin
        {rst_n, wr_stb, wr_data, reg_ptr, lat} = {2'b0, 16'h0, 2'h1, 4'hC};
        cfg = ACR_CFG_RESET[14:0];
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk();
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            {d[15], d[8]} = 2'b01;
            {d[11:9], d[7:5], d[1:0]} = {i[2:0], i[2:0], i[1:0]};
            wr(2'h1, d);
        end
        wr(2'h0, 16'h0000);
        wr(2'h1, 16'h8583);
        wr(2'h1, 16'h8583);
        repeat (100) if (conv_busy !== 1'b0) @(posedge sys_clk);
        busy = 0;
        rdchk();
        chk("starts", n_starts[15:0], starts[15:0]);
        lat <= 4'h3;
        wr(2'h1, 16'h0483);
        repeat (20) @(posedge sys_clk);
        wr(2'h1, 16'h0583);
        summarize();
    end
endmodule // tb_top
